// File: hw/core_datapath.sv
/*
 * Core datapath: fetch/execute pipeline, working register, status flags,
 * program counter and FSR held in the data space, data-bus sequencing.
 * Assumes synchronous program memory returning prog_data within one
 * instruction cycle, and a register file answering data_re by PH_READ.
 */
//Contract
//- Each instruction is one 12-bit word fetched in one instruction cycle.
//- Program and data buses are separate; data words are 8 bits.
//- Next instruction is fetched while the current one executes.
//- Non-branch instructions finish in one 200 ns instruction cycle.
//- ALU works on 8-bit operands: add, subtract, shift, logic.
//- Arithmetic uses two's complement.
//- Two-operand ops take W and a file register or literal.
//- Single-operand ops take W or a file register.
//- W is 8 bits, the accumulator, with no data address.
//- ALU updates carry, nibble carry and zero in status.
//- In subtraction carry and nibble carry act as borrow flags.
//- Special registers including program counter sit in data space, direct and indirect.
//- Any operation may target any register by any addressing mode.
//- Master clear is an active-low reset with an always-on pull-up; rst_n is a plain input with no pull-up.
//- Branches take two cycles as the prefetched word is discarded.
`timescale 1ns/1ps
`include "core_regs.svh"

module core_datapath
    import core_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [`INSTR_W-1:0] prog_data,
    output logic [`PC_W-1:0] prog_addr,
    output logic prog_rd,
    input wire logic [`DATA_W-1:0] data_rdata,
    output logic [`FADDR_W-1:0] data_addr,
    output logic data_re,
    output logic data_we,
    output logic [`DATA_W-1:0] data_wdata,
    output logic [`DATA_W-1:0] work_out,
    output logic [`DATA_W-1:0] status_out,
    output logic [`PC_W-1:0] program_counter_out,
    output logic instr_done
);

    // Internal SFRs answer reads themselves; the external file never sees them
    function automatic logic is_sfr(input logic [`FADDR_W-1:0] a);
        is_sfr = (a == `ADDR_INDIRECT) || (a == `ADDR_PC) ||
                 (a == `ADDR_STATUS) || (a == `ADDR_FSR);
    endfunction

    // Effective address: indirect slot reads through FSR
    function automatic logic [`FADDR_W-1:0] eff_addr(input logic [`INSTR_W-1:0] ins,
                                                     input logic [`DATA_W-1:0] fsr);
        if (ins[`FADDR_HI:0] == `ADDR_INDIRECT)
            eff_addr = fsr[`FADDR_W-1:0];
        else
            eff_addr = ins[`FADDR_HI:0];
    endfunction

    function automatic logic uses_file(input op_t op);
        uses_file = !(op == OP_NOP || op == OP_ADD_L || op == OP_SUB_L ||
                      op == OP_MOV_L || op == OP_JUMP);
    endfunction

    logic [`PH_W-1:0] phase_reg;
    logic [`INSTR_W-1:0] ir_reg;
    logic ir_valid_reg;
    logic [`PC_W-1:0] pc_reg;
    logic [`DATA_W-1:0] w_reg;
    logic [`DATA_W-1:0] status_reg;
    logic [`DATA_W-1:0] fsr_reg;
    logic [`DATA_W-1:0] opnd_reg;
    logic branch_reg;
    logic [`PC_W-1:0] target_reg;
    logic [`FADDR_W-1:0] ex_addr;
    logic [`DATA_W-1:0] sfr_val;
    logic [`DATA_W-1:0] f_opnd;
    logic [`DATA_W-1:0] alu_res;
    logic alu_c;
    logic alu_dc;
    logic to_file;
    logic pc_write;
    logic boundary;
    logic [`DATA_W-1:0] status_next;
    op_t op;

    assign op = op_t'(ir_reg[`OP_HI:`OP_LO]);
    assign boundary = ce && (phase_reg == `PH_LAST);
    assign ex_addr = eff_addr(ir_reg, fsr_reg);
    assign to_file = ir_reg[`DEST_BIT] || (op == OP_MOV_WF);
    assign pc_write = uses_file(op) && to_file && (ex_addr == `ADDR_PC) &&
                      (op != OP_MOV_F || ir_reg[`DEST_BIT]);

    // SPECIAL_FUNCTION_REGISTERS read mux; an indirect access to the indirect slot reads zero
    always_comb begin
        case (ex_addr)
            `ADDR_PC: sfr_val = pc_reg;
            `ADDR_STATUS: sfr_val = status_reg;
            `ADDR_FSR: sfr_val = fsr_reg;
            default: sfr_val = `ZERO8;
        endcase
    end

    // Literal ops take the immediate as second operand
    assign f_opnd = uses_file(op) ? opnd_reg : ir_reg[`LIT_HI:0];

    core_alu u_alu (
        .op(op),
        .w_opnd(w_reg),
        .f_opnd(f_opnd),
        .carry_in(status_reg[`ST_CARRY]),
        .result(alu_res),
        .carry_out(alu_c),
        .nibble_out(alu_dc)
    );

    // Flags win over a software write of status in the same instruction
    always_comb begin
        status_next = status_reg;
        if (uses_file(op) && to_file && ex_addr == `ADDR_STATUS)
            status_next = alu_res;
        case (op)
            OP_ADD_F, OP_SUB_F, OP_ADD_L, OP_SUB_L: begin
                status_next[`ST_CARRY] = alu_c;
                status_next[`ST_NIBBLE] = alu_dc;
                status_next[`ST_ZERO] = (alu_res == `ZERO8);
            end
            OP_AND_F, OP_OR_F, OP_XOR_F, OP_COM_F, OP_MOV_F, OP_CLR:
                status_next[`ST_ZERO] = (alu_res == `ZERO8);
            OP_RL_F, OP_RR_F: status_next[`ST_CARRY] = alu_c;
            default: status_next[`ST_ZERO] = status_next[`ST_ZERO];
        endcase
    end

    // Instruction-cycle phase counter; clock enable stretches the cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= '0;
        end else if (ce) begin
            if (boundary)
                phase_reg <= '0;
            else
                phase_reg <= phase_reg + 3'h1;
        end
    end

    // Fetch stage: latch next word while current one executes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_reg <= '0;
            ir_valid_reg <= 1'b0;
            pc_reg <= `PC_RST;
            prog_addr <= `PC_RST;
            prog_rd <= 1'b0;
        end else if (ce) begin
            prog_rd <= 1'b1;
            if (boundary) begin
                ir_reg <= prog_data;
                // A taken branch throws away the word fetched meanwhile
                ir_valid_reg <= !branch_reg;
                // Counter tracks the word being fetched, so a read of the slot sees it
                pc_reg <= branch_reg ? target_reg : pc_reg + 8'h01;
                prog_addr <= branch_reg ? target_reg : pc_reg + 8'h01;
            end
        end
    end

    // Data bus: address and read strobe for the operand of the new word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_addr <= '0;
            data_re <= 1'b0;
        end else if (ce) begin
            if (boundary) begin
                data_addr <= eff_addr(prog_data, fsr_reg);
                data_re <= 1'b0;
            end else if (phase_reg == '0) begin
                data_re <= ir_valid_reg && uses_file(op) && !is_sfr(ex_addr);
            end else if (phase_reg == `PH_READ) begin
                data_re <= 1'b0;
            end
        end
    end

    // Operand capture, from the file or an internal SPECIAL_FUNCTION_REGISTERS
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            opnd_reg <= `ZERO8;
        end else if (ce && phase_reg == `PH_READ) begin
            opnd_reg <= is_sfr(ex_addr) ? sfr_val : data_rdata;
        end
    end

    // Execute: write-back to W, file or SPECIAL_FUNCTION_REGISTERS, one-cycle write strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            w_reg <= `ZERO8;
            status_reg <= `STATUS_RST;
            fsr_reg <= `ZERO8;
            data_we <= 1'b0;
            data_wdata <= `ZERO8;
            branch_reg <= 1'b0;
            target_reg <= `PC_RST;
            instr_done <= 1'b0;
        end else if (ce) begin
            data_we <= 1'b0;
            instr_done <= 1'b0;
            if (boundary)
                branch_reg <= 1'b0;
            if (phase_reg == `PH_EXEC && ir_valid_reg) begin
                instr_done <= 1'b1;
                status_reg <= status_next;
                if (op == OP_JUMP) begin
                    branch_reg <= 1'b1;
                    target_reg <= ir_reg[`LIT_HI:0];
                end else if (pc_write) begin
                    branch_reg <= 1'b1;
                    target_reg <= alu_res;
                end
                if (!uses_file(op)) begin
                    if (op != OP_NOP && op != OP_JUMP)
                        w_reg <= (op == OP_MOV_L) ? ir_reg[`LIT_HI:0] : alu_res;
                end else if (!to_file) begin
                    w_reg <= alu_res;
                end else if (ex_addr == `ADDR_FSR) begin
                    fsr_reg <= alu_res;
                end else if (!is_sfr(ex_addr)) begin
                    data_we <= 1'b1;
                    data_wdata <= alu_res;
                end
            end
        end
    end

    // Observation outputs, all from flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            work_out <= `ZERO8;
            status_out <= `STATUS_RST;
            program_counter_out <= `PC_RST;
        end else if (ce) begin
            work_out <= w_reg;
            status_out <= status_reg;
            program_counter_out <= pc_reg;
        end
    end

endmodule

// File: common/core_regs.svh
/*
 * Constants of the 8-bit core: data-space map, status bit positions,
 * instruction field positions and instruction-cycle timing.
 * Assumes it is included once per compilation unit by bare name.
 */
`ifndef CORE_REGS_SVH
`define CORE_REGS_SVH

// Widths
`define DATA_W 8
`define INSTR_W 12
`define PC_W 8
`define FADDR_W 7

// Special function registers in the data space
`define ADDR_INDIRECT 7'h00
`define ADDR_PC 7'h02
`define ADDR_STATUS 7'h03
`define ADDR_FSR 7'h04

// Status register bit positions and reset value
`define ST_CARRY 0
`define ST_NIBBLE 1
`define ST_ZERO 2
`define STATUS_RST 8'h00
`define FLAG_MASK 8'h07

// Instruction fields
`define OP_HI 11
`define OP_LO 8
`define DEST_BIT 7
`define FADDR_HI 6
`define LIT_HI 7

// Instruction cycle timing
`define INSTR_CYCLE_NS 200
`define CLK_PERIOD_NS 25
`define INSTR_CLKS ((`INSTR_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PH_W 3
`define PH_READ 3'h2
`define PH_EXEC 3'h4
`define PH_LAST 3'((`INSTR_CLKS) - 1)

// Reset values
`define PC_RST 8'h00
`define ZERO8 8'h00

`endif

// File: common/core_pkg.sv
/*
 * Types of the 8-bit core: opcode enumeration.
 * Assumes core_regs.svh supplies the numeric constants.
 */
package core_pkg;

    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_ADD_F = 4'h1,
        OP_SUB_F = 4'h2,
        OP_AND_F = 4'h3,
        OP_OR_F = 4'h4,
        OP_XOR_F = 4'h5,
        OP_RL_F = 4'h6,
        OP_RR_F = 4'h7,
        OP_COM_F = 4'h8,
        OP_MOV_F = 4'h9,
        OP_MOV_WF = 4'ha,
        OP_ADD_L = 4'hb,
        OP_SUB_L = 4'hc,
        OP_MOV_L = 4'hd,
        OP_JUMP = 4'he,
        OP_CLR = 4'hf
    } op_t;

endpackage

// File: hw/core_alu.sv
/*
 * 8-bit arithmetic unit: add, subtract, shift, logic.
 * Assumes operands are stable for the cycle; purely combinational.
 */
`timescale 1ns/1ps
`include "core_regs.svh"

module core_alu
    import core_pkg::*;
(
    input wire op_t op,
    input wire logic [`DATA_W-1:0] w_opnd,
    input wire logic [`DATA_W-1:0] f_opnd,
    input wire logic carry_in,
    output logic [`DATA_W-1:0] result,
    output logic carry_out,
    output logic nibble_out
);

    logic [`DATA_W:0] sum9;
    logic [4:0] sum5;
    logic [`DATA_W-1:0] addend;
    logic sub_sel;

    // Subtract as f + ~w + 1, so carry set means no borrow
    assign sub_sel = (op == OP_SUB_F) || (op == OP_SUB_L);
    assign addend = sub_sel ? ~w_opnd : w_opnd;
    assign sum9 = {1'b0, f_opnd} + {1'b0, addend} + {8'h00, sub_sel};
    assign sum5 = {1'b0, f_opnd[3:0]} + {1'b0, addend[3:0]} + {4'h0, sub_sel};

    // Operation select
    always_comb begin
        result = f_opnd;
        carry_out = carry_in;
        nibble_out = sum5[4];
        case (op)
            OP_ADD_F, OP_ADD_L, OP_SUB_F, OP_SUB_L: begin
                result = sum9[`DATA_W-1:0];
                carry_out = sum9[`DATA_W];
            end
            OP_AND_F: result = w_opnd & f_opnd;
            OP_OR_F: result = w_opnd | f_opnd;
            OP_XOR_F: result = w_opnd ^ f_opnd;
            OP_RL_F: begin // Rotate through carry
                result = {f_opnd[`DATA_W-2:0], carry_in};
                carry_out = f_opnd[`DATA_W-1];
            end
            OP_RR_F: begin
                result = {carry_in, f_opnd[`DATA_W-1:1]};
                carry_out = f_opnd[0];
            end
            OP_COM_F: result = ~f_opnd;
            OP_MOV_WF: result = w_opnd;
            OP_CLR: result = `ZERO8;
            default: result = f_opnd;
        endcase
    end

endmodule

// File: test/core_datapath_props.sv
/*
 * Port-level checker for the core datapath, bound from the bench.
 * Assumes one clock domain and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
`include "core_regs.svh"

module core_datapath_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic prog_rd,
    input wire logic [`FADDR_W-1:0] data_addr,
    input wire logic data_re,
    input wire logic data_we,
    input wire logic [`DATA_W-1:0] work_out,
    input wire logic [`DATA_W-1:0] status_out,
    input wire logic instr_done
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Operand read strobe stands two cycles, then drops
    sequence read_burst;
        data_re ##1 !data_re;
    endsequence
    // No second completion inside one instruction cycle
    sequence quiet_seven;
        !instr_done [*7];
    endsequence

    a_done_spacing: assert property (instr_done |=> quiet_seven)
        else $error("completions closer than one instruction cycle");
    a_read_len: assert property ($rose(data_re) |=> read_burst)
        else $error("read strobe not two cycles long");
    a_we_pulse: assert property (data_we |=> !data_we)
        else $error("write strobe longer than one cycle");
    a_we_with_done: assert property (data_we |-> instr_done)
        else $error("write outside instruction completion");
    a_addr_hold: assert property (data_re |=> $stable(data_addr))
        else $error("data address moved during read");
    a_fetch_on: assert property (prog_rd |=> prog_rd)
        else $error("program read dropped while running");
    a_work_on_done: assert property ($changed(work_out) |-> $past(instr_done))
        else $error("working register changed without completion");
    a_flags_on_done: assert property ($changed(status_out) |-> $past(instr_done))
        else $error("status changed without completion");
endmodule

// File: test/core_mem_model.sv
/*
 * Program memory and data register file facing the datapath.
 * Assumes the bench preloads rom by hierarchical reference.
 */
`timescale 1ns/1ps
`include "core_regs.svh"

module core_mem_model (
    input wire logic clk,
    input wire logic [`PC_W-1:0] prog_addr,
    output logic [`INSTR_W-1:0] prog_data,
    input wire logic [`FADDR_W-1:0] data_addr,
    input wire logic data_re,
    input wire logic data_we,
    input wire logic [`DATA_W-1:0] data_wdata,
    output logic [`DATA_W-1:0] data_rdata
);
    logic [`INSTR_W-1:0] rom [0:255];
    logic [`DATA_W-1:0] rf [0:127];
    logic [`DATA_W-1:0] last_reg = 8'h5a;

    // Word follows the address at once, well before the fetch edge
    assign prog_data = rom[prog_addr];
    // Idle bus shows the inverse, so a mistimed sample cannot pass by luck
    assign data_rdata = data_re ? rf[data_addr] : ~last_reg;

    // Data side works beside the fetch, on its own bus
    always @(posedge clk) begin
        if (data_re) begin
            last_reg <= rf[data_addr];
        end
        if (data_we) begin
            rf[data_addr] <= data_wdata;
        end
    end
endmodule

// File: test/test_harvard_core_alu_datapath.sv
/*
 * Bench for the core datapath: runs a short program, checks W, flags,
 * completion spacing and a file write. Assumes the memory model beside it.
 */
`timescale 1ns/1ps
`include "core_regs.svh"

module test_harvard_core_alu_datapath;
    logic clk, rst_n, ce, prog_rd, data_re, data_we, instr_done;
    logic [`INSTR_W-1:0] prog_data;
    logic [`PC_W-1:0] prog_addr, pc_out;
    logic [`DATA_W-1:0] data_rdata, data_wdata, work_out, status_out;
    logic [`FADDR_W-1:0] data_addr;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    // Program: literal, add, store, subtract to zero, borrow, add to file, jump
    logic [11:0] prog [0:15] = '{12'hd0f, 12'hb01, 12'ha90, 12'hc10, 12'hd01, 12'hc00,
        12'h190, 12'he0a, 12'hd55, 12'hd66, 12'hd80, 12'hb80, 12'he0c, 12'h000,
        12'h000, 12'h000};
    logic [7:0] exp_w [0:10] = '{8'h0f, 8'h10, 8'h10, 8'h00, 8'h01, 8'hff, 8'hff,
        8'hff, 8'h80, 8'h00, 8'h00};
    logic [7:0] exp_st [0:10] = '{8'h00, 8'h02, 8'h02, 8'h07, 8'h07, 8'h00, 8'h01,
        8'h01, 8'h01, 8'h05, 8'h05};

    core_datapath uut (.clk(clk), .rst_n(rst_n), .ce(ce), .prog_data(prog_data),
        .prog_addr(prog_addr), .prog_rd(prog_rd), .data_rdata(data_rdata),
        .data_addr(data_addr), .data_re(data_re), .data_we(data_we),
        .data_wdata(data_wdata), .work_out(work_out), .status_out(status_out),
        .program_counter_out(pc_out), .instr_done(instr_done));
    core_mem_model mem (.clk(clk), .prog_addr(prog_addr), .prog_data(prog_data),
        .data_addr(data_addr), .data_re(data_re), .data_we(data_we),
        .data_wdata(data_wdata), .data_rdata(data_rdata));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize;
        $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Bounded wait for a completion; copies lag one cycle, so step once more
    task automatic wait_done(output int at, output bit ok);
        int k;
        for (k = 0; k < 40 && instr_done !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        ok = (instr_done === 1'b1);
        if (!ok) begin
            error_cnt++;
        end
        at = cyc;
        @(posedge clk);
        #1;
    endtask

    initial begin
        int t_prev, t_now, i;
        bit ok;
        rst_n = 1'b0;
        ce = 1'b1;
        for (i = 0; i < 16; i++) mem.rom[i] = prog[i];
        repeat (2) @(posedge clk);
        #1;
        check("work_rst", work_out, 8'h00);
        check("status_rst", status_out, 8'h00);
        check("pc_rst", pc_out, 8'h00);
        @(posedge clk);
        rst_n <= 1'b1;
        ok = 1'b1;
        for (i = 0; i < 11 && ok; i++) begin
            wait_done(t_now, ok);
            check("work", work_out, exp_w[i]);
            check("status", status_out, exp_st[i]);
            // Word i sits at address i, or two further on past the jump
            check("pc", pc_out, 8'((i < 8) ? i + 1 : i + 3));
            if (i > 0) check("gap", 8'(t_now - t_prev), (i == 8) ? 8'h10 : 8'h08);
            t_prev = t_now;
        end
        check("file_10", mem.rf[7'h10], 8'h0f);
        $display("Program test done");
        // Clock enable low must freeze the core mid-cycle, then resume
        if (ok) begin
            @(posedge clk);
            ce <= 1'b0;
            repeat (20) @(posedge clk);
            #1;
            check("pc_hold", pc_out, 8'h0d);
            check("done_hold", {7'h00, instr_done}, 8'h00);
            @(posedge clk);
            ce <= 1'b1;
            wait_done(t_now, ok);
            check("work_resume", work_out, 8'h00);
            check("status_resume", status_out, 8'h05);
        end
        $display("Freeze test done");
        summarize();
    end
endmodule

bind core_datapath core_datapath_props chk (.clk(clk), .rst_n(rst_n), .prog_rd(prog_rd),
    .data_addr(data_addr), .data_re(data_re), .data_we(data_we), .work_out(work_out),
    .status_out(status_out), .instr_done(instr_done));
